//--- inc/tcc_pkg.sv
package tcc_pkg;
  localparam int NCH = 4;
  localparam logic [9:0] BASE_BLK = 10'h200;
  localparam logic [9:0] BASE_NBLK = 10'h300;
  localparam logic [7:0] IDX_DIR = 8'hC0;
  localparam logic [7:0] IDX_FORCE = 8'hC1;
  localparam logic [7:0] IDX_CNT = 8'hC4;
  localparam logic [7:0] IDX_CTL1 = 8'hC6;
  localparam logic [7:0] IDX_TOV = 8'hC7;
  localparam logic [7:0] IDX_ACT = 8'hC8;
  localparam logic [7:0] IDX_EDGE = 8'hC9;
  localparam logic [7:0] IDX_IE = 8'hCA;
  localparam logic [7:0] IDX_CTL2 = 8'hCB;
  localparam logic [7:0] IDX_CHF = 8'hCC;
  localparam logic [7:0] IDX_OVF = 8'hCD;
  localparam logic [7:0] IDX_VAL0 = 8'hD0;
  localparam logic [7:0] IDX_PULSE_ACCUMULATOR_COUNT = 8'hD4;
  localparam logic [7:0] IDX_PAF = 8'hD5;
  localparam logic [7:0] IDX_PACTL = 8'hD6;
  localparam int CTL1_EN = 7;
  localparam int CTL1_FFCA = 4;
  localparam int CTL2_TOI = 7;
  localparam int OVF_TOF = 7;
  localparam int PAF_OVF = 1;
  localparam int PAF_IN = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int SYNC_STAGES = 2;
endpackage : tcc_pkg

//--- inc/tcc_cnt_if.sv
`timescale 1ns/1ps
interface tcc_cnt_if;
  logic en;
  logic [2:0] pr;
  logic tick;
  logic wrap;
  logic [15:0] cnt;
  modport core (input en, input pr, output tick, output wrap, output cnt);
  modport user (output en, output pr, input tick, input wrap, input cnt);
endinterface : tcc_cnt_if

//--- hdl/tcc_counter.sv
`timescale 1ns/1ps
module tcc_counter
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  tcc_cnt_if.core cif
);
  import tcc_pkg::*;
  typedef struct packed {
    logic [6:0] div;
    logic [15:0] cnt;
  } tcc_cstate_t;
  tcc_cstate_t s_r;
  tcc_cstate_t s_nxt;
  logic [6:0] mask;

  // Divide by 2**pr: tick when the low pr bits of div are all ones
  assign mask = 7'((8'h01 << cif.pr) - 8'h01);
  assign cif.tick = cif.en && ((s_r.div & mask) == mask);
  assign cif.wrap = cif.tick && (s_r.cnt == CNT_MAX);
  assign cif.cnt = s_r.cnt;

  always_comb
  begin
    s_nxt = s_r;
    if (!cif.en)
    begin
      // Stopped divider clears so a restart begins a full period
      s_nxt.div = '0;
    end
    else
    begin
      s_nxt.div = s_r.div + 7'h01;
    end
    if (cif.tick)
    begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule : tcc_counter

//--- hdl/tcc_timer.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module tcc_timer
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [tcc_pkg::NCH-1:0] cap_in,
  input wire logic pa_in,
  output logic [tcc_pkg::NCH-1:0] oc_out,
  output logic irq_out
);
  import tcc_pkg::*;
  typedef struct packed {
    logic [3:0] ios;
    logic en;
    logic ffca;
    logic [3:0] tov;
    logic [7:0] act;
    logic [7:0] edg;
    logic [3:0] ie;
    logic toi;
    logic [2:0] pr;
    logic [3:0] chf;
    logic counter_wrap_flag;
    logic [3:0][15:0] val;
    logic [15:0] pulse_accumulator_count;
    logic [1:0] paf;
    logic [1:0] pactl;
    logic [3:0] oc;
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [4:0] sy3;
    logic [31:0] prdata;
  } tcc_state_t;
  tcc_state_t s_r;
  tcc_state_t s_nxt;
  tcc_cnt_if cif ();
  logic [9:0] gaddr;
  logic [7:0] idx;
  logic hit;
  logic mapped;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic val_sel;
  logic [31:0] rd_val;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [3:0] cap;
  logic [3:0] match;
  logic [3:0] force_ev;
  logic [3:0] chf_clr;
  logic tof_clr;
  logic [1:0] paf_clr;
  logic pa_ev;
  logic pa_wrap;

  tcc_counter u_counter
  (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .cif(cif)
  );
  assign cif.en = s_r.en;
  assign cif.pr = s_r.pr;

  // Global address is paddr word index; both aliases behave alike
  assign gaddr = paddr_in[11:2];
  assign hit = (gaddr[9:8] == BASE_BLK[9:8])
            || (gaddr[9:8] == BASE_NBLK[9:8]);
  assign idx = gaddr[7:0];
  assign val_sel = (idx[7:2] == IDX_VAL0[7:2]);
  assign acc = psel_in && penable_in;
  assign wr_acc = acc && pwrite_in && mapped;
  assign rd_acc = acc && !pwrite_in && mapped;

  always_comb
  begin
    rd_val = '0;
    mapped = hit;
    if (!hit)
    begin
      mapped = 1'b0;
    end
    else if (idx == IDX_DIR)
    begin
      rd_val[3:0] = s_r.ios;
    end
    else if (idx == IDX_FORCE)
    begin
      rd_val = '0;
    end
    else if (idx == IDX_CNT)
    begin
      rd_val[15:0] = cif.cnt;
    end
    else if (idx == IDX_CTL1)
    begin
      rd_val[CTL1_EN] = s_r.en;
      rd_val[CTL1_FFCA] = s_r.ffca;
    end
    else if (idx == IDX_TOV)
    begin
      rd_val[3:0] = s_r.tov;
    end
    else if (idx == IDX_ACT)
    begin
      rd_val[7:0] = s_r.act;
    end
    else if (idx == IDX_EDGE)
    begin
      rd_val[7:0] = s_r.edg;
    end
    else if (idx == IDX_IE)
    begin
      rd_val[3:0] = s_r.ie;
    end
    else if (idx == IDX_CTL2)
    begin
      rd_val[CTL2_TOI] = s_r.toi;
      rd_val[2:0] = s_r.pr;
    end
    else if (idx == IDX_CHF)
    begin
      rd_val[3:0] = s_r.chf;
    end
    else if (idx == IDX_OVF)
    begin
      rd_val[OVF_TOF] = s_r.counter_wrap_flag;
    end
    else if (val_sel)
    begin
      rd_val[15:0] = s_r.val[idx[1:0]];
    end
    else if (idx == IDX_PULSE_ACCUMULATOR_COUNT)
    begin
      rd_val[15:0] = s_r.pulse_accumulator_count;
    end
    else if (idx == IDX_PAF)
    begin
      rd_val[1:0] = s_r.paf;
    end
    else if (idx == IDX_PACTL)
    begin
      rd_val[1:0] = s_r.pactl;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // Edge detect compares the second and third stages; a pulse must span 1 clock edge
  assign rise = s_r.sy2 & ~s_r.sy3;
  assign fall = ~s_r.sy2 & s_r.sy3;
  assign pa_ev = s_r.en && rise[4];
  assign pa_wrap = pa_ev && (s_r.pulse_accumulator_count == CNT_MAX);

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      assign cap[gi] = s_r.en && !s_r.ios[gi]
        && ((s_r.edg[2*gi] && rise[gi])
        || (s_r.edg[2*gi+1] && fall[gi]));
      assign match[gi] = cif.tick && s_r.ios[gi]
        && (cif.cnt == s_r.val[gi]);
      assign force_ev[gi] = wr_acc && (idx == IDX_FORCE)
        && pwdata_in[gi] && s_r.ios[gi];
      // Clearing by a CHF read takes only bits the reader saw; with ffca a VAL read of a capture channel or write of a compare channel clears its flag unseen
      assign chf_clr[gi] = (rd_acc && idx == IDX_CHF && s_r.prdata[gi])
        || (s_r.ffca && val_sel && idx[1:0] == 2'(gi)
        && ((rd_acc && !s_r.ios[gi])
        || (wr_acc && s_r.ios[gi])));
    end
  endgenerate

  assign tof_clr = (rd_acc && idx == IDX_OVF && s_r.prdata[OVF_TOF])
    || (s_r.ffca && acc && hit && idx == IDX_CNT);
  assign paf_clr = (rd_acc && idx == IDX_PAF) ? s_r.prdata[1:0] : 2'b00;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sy1 = {pa_in, cap_in};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    if (psel_in && !penable_in)
    begin
      s_nxt.prdata = rd_val;
    end
    if (wr_acc)
    begin
      if (idx == IDX_DIR)
      begin
        s_nxt.ios = pwdata_in[3:0];
      end
      else if (idx == IDX_CTL1)
      begin
        s_nxt.en = pwdata_in[CTL1_EN];
        s_nxt.ffca = pwdata_in[CTL1_FFCA];
      end
      else if (idx == IDX_TOV)
      begin
        s_nxt.tov = pwdata_in[3:0];
      end
      else if (idx == IDX_ACT)
      begin
        s_nxt.act = pwdata_in[7:0];
      end
      else if (idx == IDX_EDGE)
      begin
        s_nxt.edg = pwdata_in[7:0];
      end
      else if (idx == IDX_IE)
      begin
        s_nxt.ie = pwdata_in[3:0];
      end
      else if (idx == IDX_CTL2)
      begin
        s_nxt.toi = pwdata_in[CTL2_TOI];
        s_nxt.pr = pwdata_in[2:0];
      end
      else if (val_sel)
      begin
        s_nxt.val[idx[1:0]] = pwdata_in[15:0];
      end
      else if (idx == IDX_PULSE_ACCUMULATOR_COUNT)
      begin
        s_nxt.pulse_accumulator_count = pwdata_in[15:0];
      end
      else if (idx == IDX_PACTL)
      begin
        s_nxt.pactl = pwdata_in[1:0];
      end
    end
    for (int i = 0; i < NCH; i++)
    begin
      if (cap[i])
      begin
        s_nxt.val[i] = cif.cnt;
      end
      if (cif.wrap && s_r.tov[i] && s_r.ios[i])
      begin
        s_nxt.oc[i] = ~s_r.oc[i];
      end
      else if (match[i] || force_ev[i])
      begin
        case (s_r.act[2*i +: 2])
          2'b01: s_nxt.oc[i] = ~s_r.oc[i];
          2'b10: s_nxt.oc[i] = 1'b0;
          2'b11: s_nxt.oc[i] = 1'b1;
          default: s_nxt.oc[i] = s_r.oc[i];
        endcase
      end
    end
    // Set beats clear so an event in the clearing cycle survives
    s_nxt.chf = (s_r.chf & ~chf_clr) | cap | match;
    s_nxt.counter_wrap_flag = (s_r.counter_wrap_flag & ~tof_clr) | cif.wrap;
    if (s_r.ffca && acc && hit && idx == IDX_PULSE_ACCUMULATOR_COUNT)
    begin
      s_nxt.paf = 2'b00;
    end
    else
    begin
      s_nxt.paf = s_r.paf & ~paf_clr;
    end
    s_nxt.paf = s_nxt.paf | {pa_wrap, pa_ev};
    if (pa_ev)
    begin
      s_nxt.pulse_accumulator_count = s_r.pulse_accumulator_count + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata_out = s_r.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = acc && !mapped;
  assign oc_out = s_r.oc;
  assign irq_out = |(s_r.chf & s_r.ie) || (s_r.counter_wrap_flag && s_r.toi)
    || |(s_r.paf & s_r.pactl);

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_stop;
    !s_r.en |=> $stable(cif.cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved");
  property p_fast_ch;
    s_r.ffca && rd_acc && val_sel && idx[1:0] == 2'b00 && !s_r.ios[0]
      && !cap[0] |=> !s_r.chf[0];
  endproperty
  a_fast_ch: assert property (p_fast_ch) else $error("chf kept");
  property p_fast_tof;
    s_r.ffca && acc && hit && idx == IDX_CNT && !cif.wrap |=> !s_r.counter_wrap_flag;
  endproperty
  a_fast_tof: assert property (p_fast_tof) else $error("tof kept");
  property p_fast_pa;
    s_r.ffca && acc && hit && idx == IDX_PULSE_ACCUMULATOR_COUNT && !pa_ev
      |=> s_r.paf == 2'b00;
  endproperty
  a_fast_pa: assert property (p_fast_pa) else $error("paf kept");
  property p_slow;
    !s_r.ffca && s_r.counter_wrap_flag && acc && hit && idx == IDX_CNT |=> s_r.counter_wrap_flag;
  endproperty
  a_slow: assert property (p_slow) else $error("tof lost");
  property p_tog;
    cif.wrap && s_r.tov[0] && s_r.ios[0] |=> oc_out[0] != $past(oc_out[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("no wrap toggle");
  property p_div2;
    s_r.en && s_r.pr == 3'd1 && cif.tick && !wr_acc |=> !cif.tick;
  endproperty
  a_div2: assert property (p_div2) else $error("bad divide");
  property p_inmode;
    !s_r.ios[0] |=> $stable(oc_out[0]);
  endproperty
  a_inmode: assert property (p_inmode) else $error("pin moved");
  property p_cap;
    cap[0] |=> s_r.val[0] == $past(cif.cnt) && s_r.chf[0];
  endproperty
  a_cap: assert property (p_cap) else $error("capture lost");
  property p_irq;
    s_r.chf[0] && s_r.ie[0] |-> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq");
  property p_unmap;
    acc && !hit |-> pslverr_out;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no error");
  property p_wrap;
    cif.wrap |=> s_r.counter_wrap_flag && cif.cnt == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  c_cap: cover property (cap[0]);
  c_tog: cover property (cif.wrap && s_r.tov[1] && s_r.ios[1]);
  c_irq: cover property (irq_out);
endmodule : tcc_timer

//--- sim/tcc_pins_model.sv
`timescale 1ns/1ps
module tcc_pins_model
(
  input wire logic core_clk_in,
  input wire logic [3:0] oc_in,
  output logic [3:0] cap_out,
  output logic pa_out
);
  initial
  begin
    cap_out = 4'h0;
    pa_out = 1'b0;
  end

  // Line 4 is the accumulator pin; low level after release
  task automatic pulse(input int ch, input int len);
  begin
    @(posedge core_clk_in);
    if (ch < 4)
      cap_out <= cap_out | (4'h1 << ch);
    else
      pa_out <= 1'b1;
    repeat (len) @(posedge core_clk_in);
    cap_out <= 4'h0;
    pa_out <= 1'b0;
    repeat (len) @(posedge core_clk_in);
  end
  endtask : pulse
endmodule : tcc_pins_model

//--- sim/four_channel_capture_compare_timer_tb.sv
`timescale 1ns/1ps
module four_channel_capture_compare_timer_tb;
  import tcc_pkg::*;
  typedef struct packed {logic chk; logic err; logic [31:0] val;} tcc_exp_t;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, pa, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cap, oc;
  logic [15:0] c0, c1, r;
  int errors, tests_run, seed, n;
  tcc_exp_t expq[$];
  tcc_exp_t e;

  tcc_timer tcc_timer_inst (.core_clk_in(core_clk), .reset_in(reset),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cap_in(cap), .pa_in(pa),
    .oc_out(oc), .irq_out(irq));

  tcc_pins_model tcc_pins_model_inst (.core_clk_in(core_clk), .oc_in(oc),
    .cap_out(cap), .pa_out(pa));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask : check

  function automatic logic [11:0] adr(input logic nb, input logic [7:0] i);
    adr = {(nb ? BASE_NBLK : BASE_BLK) + {2'b00, i}, 2'b00};
  endfunction : adr

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
  begin
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] v,
    input logic er = 1'b0);
  begin
    expq.push_back('{1'b1, er, v});
    apb(1'b0, a, 32'h0);
  end
  endtask : rdc

  task automatic rdn(input logic [11:0] a);
  begin
    expq.push_back('{1'b0, 1'b0, 32'h0});
    apb(1'b0, a, 32'h0);
  end
  endtask : rdn

  // Read data is judged at the access edge, before the master lets go
  always @(posedge core_clk)
  begin
    if ((psel & penable & pready & ~pwrite) === 1'b1)
    begin
      e = expq.pop_front();
      if (e.chk)
      begin
        check(prdata, e.val, "read data");
        check(32'(pslverr), 32'(e.err), "bus error");
      end
    end
  end

  initial
  begin
    seed = 62966;
    errors = 0;
    tests_run = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdc(adr(0, IDX_TOV), 32'h0);
    rdc(adr(1, IDX_ACT), 32'h0);
    rdc(adr(1, IDX_CTL1), 32'h0);
    r = 16'($random(seed));
    wr(adr(1, IDX_TOV), {24'h0, r[7:0]});
    rdc(adr(0, IDX_TOV), {28'h0, r[3:0]});
    wr(adr(0, IDX_ACT), {24'h0, r[15:8]});
    rdc(adr(1, IDX_ACT), {24'h0, r[15:8]});
    wr(adr(0, IDX_VAL0 + 8'h1), {16'h0, r});
    rdc(adr(1, IDX_VAL0 + 8'h1), {16'h0, r});
    rdc(adr(0, 8'hC2), 32'h0, 1'b1);
    $display("register test done");
    wr(adr(0, IDX_CTL1), 32'h80);
    for (int p = 0; p < 8; p++)
    begin
      wr(adr(0, IDX_CTL2), 32'(p));
      repeat (300) @(posedge core_clk);
      rdn(adr(0, IDX_CNT));
      c0 = rd[15:0];
      // Latch points lie exactly 4 ticks apart
      repeat ((4 << p) - 3) @(posedge core_clk);
      rdc(adr(1, IDX_CNT), {16'h0, c0 + 16'h4});
    end
    wr(adr(0, IDX_CTL1), 32'h0);
    rdn(adr(0, IDX_CNT));
    c0 = rd[15:0];
    repeat (40) @(posedge core_clk);
    rdc(adr(0, IDX_CNT), {16'h0, c0});
    $display("prescaler test done");
    wr(adr(0, IDX_ACT), 32'h0);
    wr(adr(0, IDX_DIR), 32'h1);
    wr(adr(0, IDX_TOV), 32'h1);
    wr(adr(0, IDX_CTL2), 32'h80);
    wr(adr(0, IDX_CTL1), 32'h80);
    check(32'(oc), 32'h0, "compare pins");
    n = 0;
    while (irq !== 1'b1 && n < 70000)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
    check(32'(oc), 32'h1, "toggle on wrap");
    rdn(adr(0, IDX_CNT));
    rdc(adr(0, IDX_OVF), 32'h80);
    rdc(adr(0, IDX_OVF), 32'h0);
    @(negedge core_clk);
    check(32'(irq), 32'h0, "wrap irq");
    wr(adr(0, IDX_ACT), 32'h2);
    wr(adr(1, IDX_FORCE), 32'h1);
    @(negedge core_clk);
    check(32'(oc), 32'h0, "forced low");
    $display("wrap test done");
    wr(adr(0, IDX_DIR), 32'h0);
    wr(adr(0, IDX_EDGE), 32'h55);
    wr(adr(0, IDX_CTL2), 32'h7);
    for (int ch = 0; ch < 4; ch++)
    begin
      rdn(adr(0, IDX_CNT));
      c0 = rd[15:0];
      tcc_pins_model_inst.pulse(ch, 3 + ch);
      rdn(adr(0, IDX_CNT));
      c1 = rd[15:0];
      rdn(adr(1, IDX_VAL0 + 8'(ch)));
      check(32'(rd[15:0] >= c0 && rd[15:0] <= c1), 32'h1, "capture");
      @(negedge core_clk);
      check(32'(irq), 32'h0, "masked irq");
      wr(adr(0, IDX_IE), 32'(1 << ch));
      @(negedge core_clk);
      check(32'(irq), 32'h1, "channel irq");
      rdc(adr(0, IDX_CHF), 32'(1 << ch));
      @(negedge core_clk);
      check(32'(irq), 32'h0, "irq after clear");
    end
    wr(adr(0, IDX_CTL1), 32'h90);
    tcc_pins_model_inst.pulse(2, 8);
    rdn(adr(0, IDX_VAL0 + 8'h2));
    rdc(adr(0, IDX_CHF), 32'h0);
    $display("capture test done");
    wr(adr(0, IDX_CTL1), 32'h80);
    wr(adr(0, IDX_PULSE_ACCUMULATOR_COUNT), 32'hFFFF);
    tcc_pins_model_inst.pulse(4, 3);
    rdc(adr(0, IDX_PULSE_ACCUMULATOR_COUNT), 32'h0);
    rdc(adr(0, IDX_PAF), 32'h3);
    wr(adr(0, IDX_CTL1), 32'h90);
    tcc_pins_model_inst.pulse(4, 3);
    rdc(adr(1, IDX_PULSE_ACCUMULATOR_COUNT), 32'h1);
    rdc(adr(0, IDX_PAF), 32'h0);
    $display("accumulator test done");
    final_report();
  end

  // Longest wait is one full wrap at divide by one
  initial
  begin
    #495000;
    errors++;
    final_report();
  end

  task automatic final_report;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : final_report
endmodule : four_channel_capture_compare_timer_tb
